//--- hdl/cfgfd_cell_mem.v
// configuration cell storage: byte-wide array with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "cfgfd_regs.vh"

module cfgfd_cell_mem #(
    parameter CELLS = `CFGFD_NUM_CELLS,
    parameter IDX_W = `CFGFD_IDX_W
) (
    // clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    // write port
    input wire wr_en_i,
    input wire [IDX_W-1:0] wr_idx_i,
    input wire [7:0] wr_data_i,
    // read port
    input wire [IDX_W-1:0] rd_idx_i,
    output reg [7:0] rd_data_o
);

    // cells persist across reset like real fuses; only the read register resets
    reg [7:0] cell_ff [0:CELLS-1];
    integer k;

    // erased image loaded once at power-on in simulation and synthesis
    initial begin
        cell_ff[`CFGFD_IDX_BROWNOUT] = `CFGFD_ERASE_BROWNOUT;
        cell_ff[`CFGFD_IDX_WATCHDOG] = `CFGFD_ERASE_WATCHDOG;
        cell_ff[`CFGFD_IDX_PIN_SEL] = `CFGFD_ERASE_PIN_SEL;
        cell_ff[`CFGFD_IDX_DEBUG_BOOT] = `CFGFD_ERASE_DEBUG_BOOT;
        cell_ff[`CFGFD_IDX_CP_LOW] = `CFGFD_ERASE_CP_LOW;
        cell_ff[`CFGFD_IDX_CP_HIGH] = `CFGFD_ERASE_CP_HIGH;
        for (k = `CFGFD_NUM_CELLS; k < CELLS; k = k + 1) begin
            cell_ff[k] = 8'h00;
        end
    end

    // one byte per write, never wider
    always @(posedge mclk_i) begin
        if (wr_en_i) begin
            cell_ff[wr_idx_i] <= wr_data_i;
        end
    end

    // registered read
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= cell_ff[rd_idx_i];
        end
    end

endmodule // cfgfd_cell_mem
`default_nettype wire

//--- hdl/cfgfd_regs.vh
// register map, field positions, reset images and timing constants of the configuration fuse decoder
`ifndef CFGFD_REGS_VH
`define CFGFD_REGS_VH

// byte addresses of the configuration cells
`define CFGFD_ADDR_W 22
`define CFGFD_OFS_BROWNOUT 22'h300002
`define CFGFD_OFS_WATCHDOG 22'h300003
`define CFGFD_OFS_PIN_SEL 22'h300005
`define CFGFD_OFS_DEBUG_BOOT 22'h300006
`define CFGFD_OFS_CP_LOW 22'h300008
`define CFGFD_OFS_CP_HIGH 22'h300009

// cell indices inside the storage array
`define CFGFD_IDX_W 3
`define CFGFD_NUM_CELLS 6
`define CFGFD_IDX_BROWNOUT 3'h0
`define CFGFD_IDX_WATCHDOG 3'h1
`define CFGFD_IDX_PIN_SEL 3'h2
`define CFGFD_IDX_DEBUG_BOOT 3'h3
`define CFGFD_IDX_CP_LOW 3'h4
`define CFGFD_IDX_CP_HIGH 3'h5

// implemented-bit masks; all other positions read as zero
`define CFGFD_MASK_BROWNOUT 8'h7f
`define CFGFD_MASK_WATCHDOG 8'h7f
`define CFGFD_MASK_PIN_SEL 8'h8f
`define CFGFD_MASK_DEBUG_BOOT 8'h91
`define CFGFD_MASK_CP_LOW 8'h0f
`define CFGFD_MASK_CP_HIGH 8'hc0

// erased (unprogrammed) images
`define CFGFD_ERASE_BROWNOUT 8'h7f
`define CFGFD_ERASE_WATCHDOG 8'h7f
`define CFGFD_ERASE_PIN_SEL 8'h89
`define CFGFD_ERASE_DEBUG_BOOT 8'h81
`define CFGFD_ERASE_CP_LOW 8'h0f
`define CFGFD_ERASE_CP_HIGH 8'hc0

// clearable-only cells
`define CFGFD_CLR_ONLY_LOW 1'b1

// brown-out byte fields
`define CFGFD_BO_PWR_HI 6
`define CFGFD_BO_PWR_LO 5
`define CFGFD_BO_THR_HI 4
`define CFGFD_BO_THR_LO 3
`define CFGFD_BO_EN_HI 2
`define CFGFD_BO_EN_LO 1
`define CFGFD_BO_POWERUP_DELAY_TIMER_DIS 0

// watchdog byte fields
`define CFGFD_WD_PS_HI 6
`define CFGFD_WD_PS_LO 2
`define CFGFD_WD_EN_HI 1
`define CFGFD_WD_EN_LO 0
`define CFGFD_WD_PS_MAX 5'h14
`define CFGFD_WD_PS_RSVD 5'h1f

// pin-select byte fields
`define CFGFD_PS_RST_EN 7
`define CFGFD_PS_MASK7 3
`define CFGFD_PS_T3CK 2
`define CFGFD_PS_T0CK 1
`define CFGFD_PS_CAN 0

// debug/boot byte fields
`define CFGFD_DB_DEBUG_DIS 7
`define CFGFD_DB_BOOT_2K 4
`define CFGFD_DB_STACK_RST 0

// code-protect high byte fields
`define CFGFD_CPH_EEPROM 7
`define CFGFD_CPH_BOOT 6

// policy encodings for brown-out and watchdog; codes 2 and 1 mean nosleep and soft in opposite order
`define CFGFD_POL_W 2
`define CFGFD_BO_ALWAYS 2'h3
`define CFGFD_BO_NOSLEEP 2'h2
`define CFGFD_BO_SOFT 2'h1
`define CFGFD_WD_ALWAYS 2'h3
`define CFGFD_WD_SOFT 2'h2
`define CFGFD_WD_NOSLEEP 2'h1

// boot block end word addresses for 1 kW and 2 kW
`define CFGFD_BOOT_END_W 16
`define CFGFD_BOOT_END_1K 16'h03ff
`define CFGFD_BOOT_END_2K 16'h07ff

// self-timed write duration
`define CFGFD_CLK_KHZ 10000
`define CFGFD_WRITE_US 2000
`define CFGFD_WRITE_CYC ((`CFGFD_WRITE_US * `CFGFD_CLK_KHZ) / 1000)

`endif

//--- hdl/cfgfd_top.v
// configuration fuse decoder: byte-programmed cells, reset-time latch and decoded option outputs
//
// Function
// (R1) brown-out power field bits 6-5 selects zero-power, high, medium or low monitor.
// (R2) brown-out threshold bits 4-3 select 1.8V, 2.0V, 2.7V or 3.0V trip level.
// (R3) brown-out enable bits 2-1: always, not in sleep, software, or off.
// (R4) brown-out byte bit 0 high disables the power-up timer, low enables it.
// (R5) power-up timer enable stays independent of every brown-out setting.
// (R6) watchdog postscale bits 6-2 give ratio two to the code; 11111 reserved.
// (R7) watchdog enable bits 1-0: always, software, active-only, or off.
// (R8) pin-select bit 7 high makes shared pin a reset; low a plain input.
// (R9) pin-select bit 3 selects seven-bit (1) or five-bit (0) address masking.
// (R10) pin-select bits 2 and 1 pick timer clock pins, largest package only.
// (R11) pin-select bit 0 routes CAN pins to port B pair or alternate pair.
// (R12) debug/boot bit 7 low enables the debugger and claims its two pins.
// (R13) debug/boot bit 4 selects 2 kW or 1 kW boot block; erased value 0.
// (R14) debug/boot bit 0 high lets stack full or underflow reset the device.
// (R15) low protect bits 3-0 protect program blocks when 0; clearable only.
// (R16) high protect bits 7 and 6 protect eeprom and boot block; clearable only.
// (R17) boot protection range follows the selected boot block size.
// (R18) unimplemented bit positions always read back as zero.
// (R19) software loads address and data by table write, then starts write.
// (R20) storage is programmed one byte per write operation.
// (R21) all bytes latch during reset; outputs hold those values until next reset.
`timescale 1ns/1ps
`default_nettype none
`include "cfgfd_regs.vh"

module cfgfd_top #(
    parameter WRITE_CYC = `CFGFD_WRITE_CYC,
    parameter LARGE_PKG = 1'b1
) (
    // clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    // table write / read port
    input wire tbl_wr_i,
    input wire [`CFGFD_ADDR_W-1:0] tbl_addr_i,
    input wire [7:0] tbl_wdata_i,
    input wire wr_start_i,
    output wire wr_busy_o,
    input wire tbl_rd_i,
    output reg [7:0] tbl_rdata_o,
    output reg tbl_rvalid_o,
    // run-time inputs from the core
    input wire brownout_soft_enable_i,
    input wire watchdog_soft_enable_i,
    input wire sleep_i,
    // brown-out and power-up timer
    output reg [1:0] brownout_power_level_o,
    output reg zero_power_brownout_o,
    output reg [1:0] brownout_threshold_sel_o,
    output reg brownout_enable_o,
    output reg brownout_soft_ignored_o,
    output reg powerup_delay_timer_en_o,
    // watchdog
    output reg [4:0] watchdog_postscale_o,
    output reg watchdog_postscale_rsvd_o,
    output reg watchdog_enable_o,
    output reg watchdog_soft_ignored_o,
    // pin functions
    output reg ext_reset_pin_enable_o,
    output reg serial_addr_mask_width_o,
    output reg timer_three_clk_pin_sel_o,
    output reg timer_zero_clk_pin_sel_o,
    output reg can_pin_route_sel_o,
    // debug, boot and stack
    output reg debugger_enable_o,
    output reg boot_block_size_sel_o,
    output reg stack_fault_reset_enable_o,
    // code protection
    output reg [3:0] block_read_protect_o,
    output reg eeprom_read_protect_o,
    output reg boot_read_protect_o,
    output reg [`CFGFD_BOOT_END_W-1:0] boot_protect_end_o,
    // latch status
    output wire cfg_loaded_o
);

    // one-hot controller states
    localparam ST_LOAD = 4'b0001;
    localparam ST_IDLE = 4'b0010;
    localparam ST_WRITE = 4'b0100;
    localparam ST_READ = 4'b1000;

    localparam CNT_W = 32;

    reg [3:0] state_ff, nxt_state;
    reg [CNT_W-1:0] cnt_ff, nxt_cnt;
    reg [`CFGFD_IDX_W-1:0] load_idx_ff, nxt_load_idx;
    reg [`CFGFD_IDX_W-1:0] wr_idx_ff, nxt_wr_idx;
    reg [7:0] wr_data_ff, nxt_wr_data;
    reg wr_valid_ff, nxt_wr_valid;
    reg [`CFGFD_IDX_W-1:0] rd_idx_ff, nxt_rd_idx;
    reg loaded_ff, nxt_loaded;
    reg load_pend_ff;
    reg [7:0] shadow_ff [0:`CFGFD_NUM_CELLS-1];

    reg mem_wr;
    reg [`CFGFD_IDX_W-1:0] mem_rd_idx;
    wire [7:0] mem_rdata;
    reg [`CFGFD_IDX_W-1:0] addr_idx;
    reg addr_hit;
    reg [7:0] addr_mask;
    reg [7:0] cell_mask;
    reg [7:0] merged;
    reg [7:0] cur_cell;
    integer i;

    // address decode to cell index and implemented-bit mask
    always @* begin
        addr_hit = 1'b1;
        addr_idx = `CFGFD_IDX_BROWNOUT;
        addr_mask = 8'h00;
        case (tbl_addr_i)
            `CFGFD_OFS_BROWNOUT: begin
                addr_idx = `CFGFD_IDX_BROWNOUT;
                addr_mask = `CFGFD_MASK_BROWNOUT;
            end
            `CFGFD_OFS_WATCHDOG: begin
                addr_idx = `CFGFD_IDX_WATCHDOG;
                addr_mask = `CFGFD_MASK_WATCHDOG;
            end
            `CFGFD_OFS_PIN_SEL: begin
                addr_idx = `CFGFD_IDX_PIN_SEL;
                addr_mask = `CFGFD_MASK_PIN_SEL;
            end
            `CFGFD_OFS_DEBUG_BOOT: begin
                addr_idx = `CFGFD_IDX_DEBUG_BOOT;
                addr_mask = `CFGFD_MASK_DEBUG_BOOT;
            end
            `CFGFD_OFS_CP_LOW: begin
                addr_idx = `CFGFD_IDX_CP_LOW;
                addr_mask = `CFGFD_MASK_CP_LOW;
            end
            `CFGFD_OFS_CP_HIGH: begin
                addr_idx = `CFGFD_IDX_CP_HIGH;
                addr_mask = `CFGFD_MASK_CP_HIGH;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // mask and clear-only rules for the pending write cell
    always @* begin
        cur_cell = mem_rdata;
        case (wr_idx_ff)
            `CFGFD_IDX_BROWNOUT: cell_mask = `CFGFD_MASK_BROWNOUT;
            `CFGFD_IDX_WATCHDOG: cell_mask = `CFGFD_MASK_WATCHDOG;
            `CFGFD_IDX_PIN_SEL: cell_mask = `CFGFD_MASK_PIN_SEL;
            `CFGFD_IDX_DEBUG_BOOT: cell_mask = `CFGFD_MASK_DEBUG_BOOT;
            `CFGFD_IDX_CP_LOW: cell_mask = `CFGFD_MASK_CP_LOW;
            `CFGFD_IDX_CP_HIGH: cell_mask = `CFGFD_MASK_CP_HIGH;
            default: cell_mask = 8'h00;
        endcase
        merged = wr_data_ff & cell_mask; // R18
        if ((wr_idx_ff == `CFGFD_IDX_CP_LOW) || (wr_idx_ff == `CFGFD_IDX_CP_HIGH)) begin
            merged = merged & cur_cell; // R15 R16
        end
        if (!LARGE_PKG && (wr_idx_ff == `CFGFD_IDX_PIN_SEL)) begin
            // small packages keep the timer clock select bits at zero
            merged[`CFGFD_PS_T3CK] = 1'b0; // R10
            merged[`CFGFD_PS_T0CK] = 1'b0; // R10
        end
    end

    // controller: reset-time load, self-timed byte write, registered read
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_load_idx = load_idx_ff;
        nxt_wr_idx = wr_idx_ff;
        nxt_wr_data = wr_data_ff;
        nxt_wr_valid = wr_valid_ff;
        nxt_rd_idx = rd_idx_ff;
        nxt_loaded = loaded_ff;
        mem_wr = 1'b0;
        mem_rd_idx = load_idx_ff;
        // table write only stages address and data
        if (tbl_wr_i && addr_hit && (state_ff != ST_WRITE)) begin
            nxt_wr_idx = addr_idx; // R19
            nxt_wr_data = tbl_wdata_i;
            nxt_wr_valid = 1'b1;
        end
        case (state_ff)
            ST_LOAD: begin
                mem_rd_idx = load_idx_ff;
                if (load_pend_ff) begin
                    if (load_idx_ff == `CFGFD_NUM_CELLS - 1) begin
                        nxt_state = ST_IDLE;
                        nxt_loaded = 1'b1; // R21
                    end else begin
                        nxt_load_idx = load_idx_ff + 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                mem_rd_idx = addr_idx;
                if (wr_start_i && wr_valid_ff) begin
                    nxt_state = ST_WRITE; // R19
                    nxt_cnt = WRITE_CYC - 1;
                end else if (tbl_rd_i) begin
                    nxt_state = ST_READ;
                    nxt_rd_idx = addr_idx;
                end
            end
            ST_WRITE: begin
                mem_rd_idx = wr_idx_ff;
                if (cnt_ff == 0) begin
                    mem_wr = 1'b1; // R20
                    nxt_wr_valid = 1'b0;
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            ST_READ: begin
                mem_rd_idx = rd_idx_ff;
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state registers
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= ST_LOAD;
            cnt_ff <= {CNT_W{1'b0}};
            load_idx_ff <= {`CFGFD_IDX_W{1'b0}};
            wr_idx_ff <= {`CFGFD_IDX_W{1'b0}};
            wr_data_ff <= 8'h00;
            wr_valid_ff <= 1'b0;
            rd_idx_ff <= {`CFGFD_IDX_W{1'b0}};
            loaded_ff <= 1'b0;
            load_pend_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            load_idx_ff <= nxt_load_idx;
            wr_idx_ff <= nxt_wr_idx;
            wr_data_ff <= nxt_wr_data;
            wr_valid_ff <= nxt_wr_valid;
            rd_idx_ff <= nxt_rd_idx;
            loaded_ff <= nxt_loaded;
            // one cycle of read latency per loaded cell
            load_pend_ff <= (state_ff == ST_LOAD) && !load_pend_ff;
        end
    end

    // shadow copy captured only while loading after reset
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (i = 0; i < `CFGFD_NUM_CELLS; i = i + 1) begin
                shadow_ff[i] <= 8'h00;
            end
        end else if ((state_ff == ST_LOAD) && load_pend_ff) begin
            shadow_ff[load_idx_ff] <= mem_rdata; // R21
        end
    end

    // read-back register; unmapped addresses answer the brown-out cell
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tbl_rdata_o <= 8'h00;
            tbl_rvalid_o <= 1'b0;
        end else begin
            tbl_rvalid_o <= (state_ff == ST_READ);
            if (state_ff == ST_READ) begin
                tbl_rdata_o <= mem_rdata; // R18
            end
        end
    end

    cfgfd_cell_mem #(
        .CELLS(`CFGFD_NUM_CELLS),
        .IDX_W(`CFGFD_IDX_W)
    ) u_mem (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .wr_en_i(mem_wr),
        .wr_idx_i(wr_idx_ff),
        .wr_data_i(merged),
        .rd_idx_i(mem_rd_idx),
        .rd_data_o(mem_rdata)
    );

    assign wr_busy_o = (state_ff == ST_WRITE);
    assign cfg_loaded_o = loaded_ff;

    // decode of latched bytes; sleep and soft enables are same-clock core signals
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            brownout_power_level_o <= 2'h0;
            zero_power_brownout_o <= 1'b0;
            brownout_threshold_sel_o <= 2'h0;
            brownout_enable_o <= 1'b0;
            brownout_soft_ignored_o <= 1'b0;
            powerup_delay_timer_en_o <= 1'b0;
            watchdog_postscale_o <= 5'h00;
            watchdog_postscale_rsvd_o <= 1'b0;
            watchdog_enable_o <= 1'b0;
            watchdog_soft_ignored_o <= 1'b0;
            ext_reset_pin_enable_o <= 1'b0;
            serial_addr_mask_width_o <= 1'b0;
            timer_three_clk_pin_sel_o <= 1'b0;
            timer_zero_clk_pin_sel_o <= 1'b0;
            can_pin_route_sel_o <= 1'b0;
            debugger_enable_o <= 1'b0;
            boot_block_size_sel_o <= 1'b0;
            stack_fault_reset_enable_o <= 1'b0;
            block_read_protect_o <= 4'h0;
            eeprom_read_protect_o <= 1'b0;
            boot_read_protect_o <= 1'b0;
            boot_protect_end_o <= `CFGFD_BOOT_END_1K;
        end else if (loaded_ff) begin
            brownout_power_level_o <= shadow_ff[`CFGFD_IDX_BROWNOUT][`CFGFD_BO_PWR_HI:`CFGFD_BO_PWR_LO]; // R1
            zero_power_brownout_o <= &shadow_ff[`CFGFD_IDX_BROWNOUT][`CFGFD_BO_PWR_HI:`CFGFD_BO_PWR_LO]; // R1
            brownout_threshold_sel_o <= shadow_ff[`CFGFD_IDX_BROWNOUT][`CFGFD_BO_THR_HI:`CFGFD_BO_THR_LO]; // R2
            case (shadow_ff[`CFGFD_IDX_BROWNOUT][`CFGFD_BO_EN_HI:`CFGFD_BO_EN_LO])
                `CFGFD_BO_ALWAYS: begin
                    brownout_enable_o <= 1'b1; // R3
                    brownout_soft_ignored_o <= 1'b1;
                end
                `CFGFD_BO_NOSLEEP: begin
                    brownout_enable_o <= !sleep_i; // R3
                    brownout_soft_ignored_o <= 1'b1;
                end
                `CFGFD_BO_SOFT: begin
                    brownout_enable_o <= brownout_soft_enable_i; // R3
                    brownout_soft_ignored_o <= 1'b0;
                end
                default: begin
                    brownout_enable_o <= 1'b0; // R3
                    brownout_soft_ignored_o <= 1'b1;
                end
            endcase
            // read from its own bit only, never gated by brown-out fields
            powerup_delay_timer_en_o <= !shadow_ff[`CFGFD_IDX_BROWNOUT][`CFGFD_BO_POWERUP_DELAY_TIMER_DIS]; // R4 R5
            watchdog_postscale_o <= shadow_ff[`CFGFD_IDX_WATCHDOG][`CFGFD_WD_PS_HI:`CFGFD_WD_PS_LO]; // R6
            // codes above the largest ratio, 11111 included, are flagged as reserved
            watchdog_postscale_rsvd_o <=
                shadow_ff[`CFGFD_IDX_WATCHDOG][`CFGFD_WD_PS_HI:`CFGFD_WD_PS_LO] > `CFGFD_WD_PS_MAX; // R6
            case (shadow_ff[`CFGFD_IDX_WATCHDOG][`CFGFD_WD_EN_HI:`CFGFD_WD_EN_LO])
                `CFGFD_WD_ALWAYS: begin
                    watchdog_enable_o <= 1'b1; // R7
                    watchdog_soft_ignored_o <= 1'b1;
                end
                `CFGFD_WD_SOFT: begin
                    watchdog_enable_o <= watchdog_soft_enable_i; // R7
                    watchdog_soft_ignored_o <= 1'b0;
                end
                `CFGFD_WD_NOSLEEP: begin
                    watchdog_enable_o <= !sleep_i; // R7
                    watchdog_soft_ignored_o <= 1'b1;
                end
                default: begin
                    watchdog_enable_o <= 1'b0; // R7
                    watchdog_soft_ignored_o <= 1'b1;
                end
            endcase
            ext_reset_pin_enable_o <= shadow_ff[`CFGFD_IDX_PIN_SEL][`CFGFD_PS_RST_EN]; // R8
            serial_addr_mask_width_o <= shadow_ff[`CFGFD_IDX_PIN_SEL][`CFGFD_PS_MASK7]; // R9
            timer_three_clk_pin_sel_o <= LARGE_PKG & shadow_ff[`CFGFD_IDX_PIN_SEL][`CFGFD_PS_T3CK]; // R10
            timer_zero_clk_pin_sel_o <= LARGE_PKG & shadow_ff[`CFGFD_IDX_PIN_SEL][`CFGFD_PS_T0CK]; // R10
            can_pin_route_sel_o <= shadow_ff[`CFGFD_IDX_PIN_SEL][`CFGFD_PS_CAN]; // R11
            debugger_enable_o <= !shadow_ff[`CFGFD_IDX_DEBUG_BOOT][`CFGFD_DB_DEBUG_DIS]; // R12
            boot_block_size_sel_o <= shadow_ff[`CFGFD_IDX_DEBUG_BOOT][`CFGFD_DB_BOOT_2K]; // R13
            stack_fault_reset_enable_o <= shadow_ff[`CFGFD_IDX_DEBUG_BOOT][`CFGFD_DB_STACK_RST]; // R14
            block_read_protect_o <= ~shadow_ff[`CFGFD_IDX_CP_LOW][3:0]; // R15
            eeprom_read_protect_o <= !shadow_ff[`CFGFD_IDX_CP_HIGH][`CFGFD_CPH_EEPROM]; // R16
            boot_read_protect_o <= !shadow_ff[`CFGFD_IDX_CP_HIGH][`CFGFD_CPH_BOOT]; // R16
            boot_protect_end_o <= shadow_ff[`CFGFD_IDX_DEBUG_BOOT][`CFGFD_DB_BOOT_2K] ?
                `CFGFD_BOOT_END_2K : `CFGFD_BOOT_END_1K; // R17
        end
    end

endmodule // cfgfd_top
`default_nettype wire

//--- tb/cfgfd_props.sv
// port checker for the configuration fuse decoder
`timescale 1ns/1ps
`default_nettype none
module cfgfd_props #(
    parameter WRITE_CYC = 4
) (
    // clock, reset and access port
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic wr_start_i,
    input wire logic wr_busy_o,
    input wire logic tbl_rd_i,
    input wire logic tbl_rvalid_o,
    // core inputs
    input wire logic brownout_soft_enable_i,
    input wire logic watchdog_soft_enable_i,
    // decoded outputs
    input wire logic [1:0] brownout_power_level_o,
    input wire logic zero_power_brownout_o,
    input wire logic brownout_enable_o,
    input wire logic brownout_soft_ignored_o,
    input wire logic [4:0] watchdog_postscale_o,
    input wire logic watchdog_postscale_rsvd_o,
    input wire logic watchdog_enable_o,
    input wire logic watchdog_soft_ignored_o,
    input wire logic debugger_enable_o,
    input wire logic boot_block_size_sel_o,
    input wire logic [3:0] block_read_protect_o,
    input wire logic [15:0] boot_protect_end_o,
    input wire logic cfg_loaded_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    logic [15:0] busy_cnt_ff;
    // length of the current self-timed write, cleared when idle
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) busy_cnt_ff <= 16'h0;
        else busy_cnt_ff <= wr_busy_o ? busy_cnt_ff + 16'h1 : 16'h0;
    end
    a_zero_power_sel: assert property (cfg_loaded_o |-> zero_power_brownout_o == (brownout_power_level_o == 2'h3))
        else $error("zero-power flag wrong");
    a_postscale_rsvd: assert property (cfg_loaded_o |-> watchdog_postscale_rsvd_o == (watchdog_postscale_o > 5'h14))
        else $error("reserved postscale flag wrong");
    a_boot_range: assert property (cfg_loaded_o |-> boot_protect_end_o == (boot_block_size_sel_o ? 16'h07ff : 16'h03ff))
        else $error("boot end wrong");
    a_bo_soft: assert property (cfg_loaded_o && $past(cfg_loaded_o, 3) && !brownout_soft_ignored_o
        |-> brownout_enable_o == $past(brownout_soft_enable_i))
        else $error("brown-out soft enable lost");
    a_wd_soft: assert property (cfg_loaded_o && $past(cfg_loaded_o, 3) && !watchdog_soft_ignored_o
        |-> watchdog_enable_o == $past(watchdog_soft_enable_i))
        else $error("watchdog soft enable lost");
    a_frozen_outs: assert property (cfg_loaded_o && $past(cfg_loaded_o, 3) |-> $stable(brownout_power_level_o)
        && $stable(watchdog_postscale_o) && $stable(block_read_protect_o) && $stable(boot_block_size_sel_o))
        else $error("output moved");
    a_unloaded_quiet: assert property (!cfg_loaded_o |-> !debugger_enable_o && block_read_protect_o == 4'h0)
        else $error("output before load");
    a_busy_cause: assert property ($rose(wr_busy_o) |-> $past(wr_start_i) || $past(wr_start_i, 2))
        else $error("write busy without start");
    a_busy_length: assert property (cfg_loaded_o && $fell(wr_busy_o) |-> busy_cnt_ff == WRITE_CYC)
        else $error("write length wrong");
    a_rvalid_pulse: assert property ($rose(tbl_rvalid_o) |-> ($past(tbl_rd_i, 2) || $past(tbl_rd_i, 3))
        ##1 !tbl_rvalid_o)
        else $error("stray read valid");
endmodule // cfgfd_props
// every checker port shares its name with a port of the decoder
bind cfgfd_top cfgfd_props #(.WRITE_CYC(WRITE_CYC)) cfgfd_props_i (.*);
`default_nettype wire

//--- tb/config_fuse_decoder_test.sv
// self-checking bench for the configuration fuse decoder
`timescale 1ns/1ps
`default_nettype none
module config_fuse_decoder_test;
    logic mclk_i = 1'b0, arst_n_i = 1'b0, tbl_wr_i = 1'b0, wr_start_i = 1'b0, tbl_rd_i = 1'b0;
    logic bse = 1'b0, wse = 1'b0, slp = 1'b1;
    logic [21:0] tbl_addr_i = 22'h0;
    logic [7:0] tbl_wdata_i = 8'h0, rdata;
    logic [1:0] pl, thr;
    logic zp, boe, bsi, pwe, rsv, wde, wsi, ext, msk, t3, t0, can, dbg, bbs, stk, eep, bpr, ld, busy, rv;
    logic [4:0] ps;
    logic [3:0] bp;
    logic [15:0] bend;
    int cmp_count = 0, mismatches = 0;
    wire [43:0] dec = {pl, zp, thr, bsi, pwe, ps, rsv, wsi, ext, msk, t3, t0, can, dbg, bbs, stk, bp, eep, bpr, bend};
    // expected decode images
    localparam logic [43:0] ERASED = {2'h3, 1'h1, 2'h3, 1'h1, 1'h0, 5'h1f, 2'h3, 5'h19, 3'h1, 6'h0, 16'h03ff};
    localparam logic [43:0] PROGRAMMED = {2'h0, 1'h0, 2'h1, 1'h0, 1'h1, 5'h14, 2'h0, 5'h0e, 3'h6, 6'h16, 16'h07ff};
    logic [21:0] adr [0:5] = '{22'h300002, 22'h300003, 22'h300005, 22'h300006, 22'h300008, 22'h300009};
    // writes carry junk in unimplemented bits on purpose
    logic [7:0] wv [0:5] = '{8'h8a, 8'h52, 8'h7e, 8'h7e, 8'hfa, 8'h7f};
    logic [7:0] er [0:5] = '{8'h7f, 8'h7f, 8'h89, 8'h81, 8'h0f, 8'hc0};
    logic [7:0] nw [0:5] = '{8'h0a, 8'h52, 8'h0e, 8'h10, 8'h0a, 8'h40};
    cfgfd_top #(.WRITE_CYC(4), .LARGE_PKG(1'b1)) cfgfd_top_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .tbl_wr_i(tbl_wr_i), .tbl_addr_i(tbl_addr_i), .tbl_wdata_i(tbl_wdata_i), .wr_start_i(wr_start_i),
        .wr_busy_o(busy), .tbl_rd_i(tbl_rd_i), .tbl_rdata_o(rdata), .tbl_rvalid_o(rv),
        .brownout_soft_enable_i(bse), .watchdog_soft_enable_i(wse), .sleep_i(slp),
        .brownout_power_level_o(pl), .zero_power_brownout_o(zp), .brownout_threshold_sel_o(thr),
        .brownout_enable_o(boe), .brownout_soft_ignored_o(bsi), .powerup_delay_timer_en_o(pwe),
        .watchdog_postscale_o(ps), .watchdog_postscale_rsvd_o(rsv), .watchdog_enable_o(wde),
        .watchdog_soft_ignored_o(wsi), .ext_reset_pin_enable_o(ext), .serial_addr_mask_width_o(msk),
        .timer_three_clk_pin_sel_o(t3), .timer_zero_clk_pin_sel_o(t0), .can_pin_route_sel_o(can),
        .debugger_enable_o(dbg), .boot_block_size_sel_o(bbs), .stack_fault_reset_enable_o(stk),
        .block_read_protect_o(bp), .eeprom_read_protect_o(eep), .boot_read_protect_o(bpr),
        .boot_protect_end_o(bend), .cfg_loaded_o(ld));
    // 10 MHz clock
    always #50 mclk_i = ~mclk_i;
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [43:0] got, input logic [43:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic tmo(input string what);
        mismatches++;
        $display("unexpected at %0t: timeout on %s", $time, what);
        test_done();
    endtask
    // inputs always move 1 ns after the rising edge
    task automatic cyc;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic wt_busy(input logic lvl);
        int i;
        for (i = 0; i < 30 && busy !== lvl; i++) cyc();
        if (busy !== lvl) tmo("busy");
    endtask
    task automatic rst;
        int i;
        arst_n_i = 1'b0;
        repeat (5) cyc();
        chk(dec, {28'h0, 16'h03ff}, "outputs in reset");
        arst_n_i = 1'b1;
        for (i = 0; i < 40 && ld !== 1'b1; i++) cyc();
        if (ld !== 1'b1) tmo("load");
        repeat (2) cyc();
    endtask
    // stage a byte, start the self-timed write, wait it out
    task automatic wr(input logic [21:0] a, input logic [7:0] d);
        tbl_wr_i = 1'b1;
        tbl_addr_i = a;
        tbl_wdata_i = d;
        cyc();
        tbl_wr_i = 1'b0;
        wr_start_i = 1'b1;
        cyc();
        wr_start_i = 1'b0;
        wt_busy(1'b1);
        wt_busy(1'b0);
    endtask
    task automatic rd(input logic [21:0] a, input logic [7:0] e);
        int i;
        tbl_rd_i = 1'b1;
        tbl_addr_i = a;
        cyc();
        tbl_rd_i = 1'b0;
        for (i = 0; i < 4 && rv !== 1'b1; i++) cyc();
        chk({35'h0, rv, rdata}, {35'h0, 1'b1, e}, "read");
        cyc();
    endtask
    initial begin
        int k;
        rst();
        chk(dec, ERASED, "erased decode");
        chk({42'h0, boe, wde}, {42'h0, 2'h3}, "always on in sleep");
        for (k = 0; k < 6; k++) rd(adr[k], er[k]);
        $display("test erased done");
        for (k = 0; k < 6; k++) wr(adr[k], wv[k]);
        for (k = 0; k < 6; k++) rd(adr[k], nw[k]);
        chk(dec, ERASED, "held until reset");
        // protect cells may only be cleared, never set again
        wr(adr[4], 8'h0f);
        rd(adr[4], 8'h0a);
        $display("test program done");
        rst();
        chk(dec, PROGRAMMED, "programmed decode");
        slp = 1'b0;
        bse = 1'b1;
        wse = 1'b1;
        repeat (2) cyc();
        chk({42'h0, boe, wde}, {42'h0, 2'h3}, "soft enables on");
        bse = 1'b0;
        wse = 1'b0;
        repeat (2) cyc();
        chk({42'h0, boe, wde}, {42'h0, 2'h0}, "soft enables off");
        $display("test soft enable done");
        test_done();
    end
endmodule // config_fuse_decoder_test
`default_nettype wire
